// ### hw/prd_mcu.sv
// Memory control unit end: decodes qualified requests and keeps the internal registers.
`timescale 1ns/1ps
`default_nettype none
`include "prd_defines.svh"
module prd_mcu #(
  parameter int PT_DEPTH  = `PRD_PT_DEPTH,
  parameter int DIR_DEPTH = `PRD_DIR_DEPTH
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // Request link
  prd_link_if.mcu                        link,
  // Memory error events and data sources
  input  wire logic                      par_err_i,
  input  wire logic                      nxm_err_i,
  input  wire logic [`PRD_AW-1:0]        cur_addr_i,
  input  wire logic [`PRD_DW-1:0]        storage_bus_data_i,
  input  wire logic [`PRD_DW-1:0]        cache_data_i,
  input  wire logic [`PRD_DW-1:0]        chan_data_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // Cache clear start, refill quarter enables, data path, interrupt
  output logic                           clr_start_o,
  output logic [`PRD_CCA_QW-1:0]         clr_mode_o,
  output logic [3:0]                     quarter_en_o,
  output logic [`PRD_DW-1:0]             dpath_o,
  output logic [`PRD_DW-1:0]             diag_data_o,
  output logic                           irq_o
);
  import prd_pkg::*;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [`PRD_DW-1:0]         user_base_register;
    logic [`PRD_DW-1:0]         exec_base_register;
    logic [`PRD_DW-1:0]         cca;
    logic [`PRD_DW-1:0]         error_address_register;
    logic [`PRD_DW-1:0]         hold;
    logic [5:0]                 dsel;
    logic                       rmw_armed;
    logic                       done;
    logic                       clr;
    logic [`PRD_CCA_QW-1:0]     clr_mode;
    logic [3:0]                 qen;
    logic [`PRD_DW-1:0]         dpath;
    logic [`PRD_DW-1:0]         ddata;
    logic [`PRD_IRQ_W-1:0]      stat;
    logic [`PRD_IRQ_W-1:0]      mask;
    logic [31:0]                wdat;
    logic                       ack;
    logic                       irq;
  } prd_mcu_s;
  prd_mcu_s st_ff, nxt_st;
  logic [3:0]                   refill_ff [`PRD_RAM_DEPTH];
  logic [`PRD_PHYS_HI:0]        pt_ff [PT_DEPTH];
  logic [`PRD_SEC_HI-`PRD_SEC_LO:0] dir_ff [DIR_DEPTH];
  prd_op_e                      op;
  prd_op_e                      act_op;
  logic [`PRD_PT_AW-1:0]        pt_idx;
  logic [`PRD_DIR_AW-1:0]       dir_idx;
  logic [`PRD_RAM_AW-1:0]       ram_idx;
  logic [`PRD_IRQ_W-1:0]        ev;
  assign pt_idx  = link.virtual_address_register[`PRD_PAGE_HI:`PRD_PAGE_LO];
  assign dir_idx = link.virtual_address_register[`PRD_SEC_HI:`PRD_SEC_LO];
  assign ram_idx = link.virtual_address_register[`PRD_RAM_AW-1:0];
  // A request stands until the execution unit sees done, so the answer cycle must not run it twice.
  assign act_op  = prd_op_e'(st_ff.done ? PRD_OP_NONE : op);
  prd_decode u_dec (
    .req_i    (link.execution_request),
    .rd_i     (link.read_qualifier),
    .pause_i  (link.pause_qualifier),
    .wr_i     (link.write_qualifier),
    .sdiag_i  (link.bus_diagnostic_qualifier),
    .ldreg_i  (link.load_reg_qualifier),
    .rdreg_i  (link.read_register_qualifier),
    .map_i    (link.map_qualifier),
    .refill_i (link.refill_wr),
    .ptwr_i   (link.pt_wr),
    .dirwr_i  (link.pt_dir_wr),
    .dload_i  (link.diag_load),
    .op_o     (op)
  );
  // Picks the diagnostic register addressed by the front end.
  function automatic logic [`PRD_DW-1:0] diag_pick(input logic [2:0] n, input prd_mcu_s s);
    unique case (n)
      3'h0:    diag_pick = s.user_base_register;
      3'h1:    diag_pick = s.exec_base_register;
      3'h2:    diag_pick = s.cca;
      3'h3:    diag_pick = s.error_address_register;
      3'h4:    diag_pick = s.hold;
      3'h5:    diag_pick = {30'h0, s.dsel};
      3'h6:    diag_pick = s.dpath;
      default: diag_pick = {{(`PRD_DW-`PRD_IRQ_W){1'b0}}, s.stat};
    endcase
  endfunction : diag_pick
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.clr = 1'b0;
    nxt_st.ack = 1'b0;
    ev = '0;
    unique case (act_op)
      PRD_OP_LDREG: begin
        nxt_st.done = 1'b1;
        unique case (link.reg_sel)
          PRD_REG_EBR: nxt_st.exec_base_register = link.virtual_address_register;
          PRD_REG_CCA: begin
            nxt_st.cca = link.virtual_address_register;
            nxt_st.clr = 1'b1;
            nxt_st.clr_mode = link.cca_qual;
            ev[`PRD_IRQ_CLR] = 1'b1;
          end
          default: nxt_st.user_base_register = link.virtual_address_register;
        endcase
      end
      PRD_OP_RDREG: begin
        nxt_st.done = 1'b1;
        unique case (link.reg_sel)
          PRD_REG_EBR: nxt_st.hold = st_ff.exec_base_register;
          PRD_REG_CCA: nxt_st.hold = st_ff.cca;
          PRD_REG_ERA: nxt_st.hold = st_ff.error_address_register;
          default:     nxt_st.hold = st_ff.user_base_register;
        endcase
      end
      PRD_OP_MAP: begin
        nxt_st.done = 1'b1;
        nxt_st.hold = {{(`PRD_DW-`PRD_PHYS_HI-1){1'b0}}, pt_ff[pt_idx]};
      end
      PRD_OP_REFILL: nxt_st.done = 1'b1;
      PRD_OP_RMW1: begin
        nxt_st.done = 1'b1;
        nxt_st.rmw_armed = 1'b1;
      end
      PRD_OP_WRITE: begin
        nxt_st.done = 1'b1;
        if (st_ff.rmw_armed) begin
          nxt_st.rmw_armed = 1'b0;
          ev[`PRD_IRQ_RMW] = 1'b1;
        end
      end
      PRD_OP_SDIAG: begin
        nxt_st.done = 1'b1;
        ev[`PRD_IRQ_DIAG] = 1'b1;
      end
      // source select from data bits 30-35.
      PRD_OP_DDIAG: nxt_st.dsel = link.io_data[`PRD_DDIAG_HI:`PRD_DDIAG_LO];
      PRD_OP_READ, PRD_OP_WCHK: nxt_st.done = 1'b1;
      default: ;
    endcase
    if (par_err_i || nxm_err_i) begin
      nxt_st.error_address_register = {cur_addr_i[`PRD_AW-1-`PRD_ERRSRC_W:0], par_err_i ? `PRD_SRC_PAR : `PRD_SRC_NXM};
      ev[`PRD_IRQ_ERR] = 1'b1;
    end
    // quarters used follow the refill table.
    nxt_st.qen = refill_ff[ram_idx];
    unique case (st_ff.dsel)
      `PRD_DP_STORAGE_BUS:  nxt_st.dpath = storage_bus_data_i;
      `PRD_DP_CACHE: nxt_st.dpath = cache_data_i;
      `PRD_DP_CHAN:  nxt_st.dpath = chan_data_i;
      `PRD_DP_AR:    nxt_st.dpath = link.arithmetic_register;
      default:       nxt_st.dpath = '0;
    endcase
    if (link.diag_read) begin
      nxt_st.ddata = diag_pick(link.diag_sel, st_ff);
    end
    // Wishbone: 0 status (write one clears), 4 mask. Set beats clear.
    if (wb_cyc_i && wb_stb_i && !st_ff.ack) begin
      nxt_st.ack = 1'b1;
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `PRD_WB_STAT) nxt_st.stat = st_ff.stat & ~wb_dat_i[`PRD_IRQ_W-1:0];
        if (wb_adr_i == `PRD_WB_MASK) nxt_st.mask = wb_dat_i[`PRD_IRQ_W-1:0];
      end
      nxt_st.wdat = (wb_adr_i == `PRD_WB_STAT) ? {28'h0, st_ff.stat} :
                    (wb_adr_i == `PRD_WB_MASK) ? {28'h0, st_ff.mask} : 32'h0;
    end
    nxt_st.stat = nxt_st.stat | ev;
    // Interrupt is registered from the next status and mask, so it moves with them.
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
    if (rst_i) begin
      nxt_st = '0;
    end
  end
  // ---------------------------------------------------------------
  // Registers and tables
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i || rst_i) begin
      st_ff <= nxt_st;
    end
  end
  // Table writes; directory clear when switching users.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (act_op == PRD_OP_REFILL) refill_ff[ram_idx] <= link.arithmetic_register[3:0];
      if (act_op == PRD_OP_PTWR) pt_ff[pt_idx] <= link.arithmetic_register[`PRD_PHYS_HI:`PRD_PHYS_LO];
      for (int i = 0; i < DIR_DEPTH; i++) begin
        if (act_op == PRD_OP_DIRWR) dir_ff[i] <= '0;
        // section into directory, newer mode only.
        if (act_op == PRD_OP_PTWR && link.newer_paging_mode && dir_idx == i[`PRD_DIR_AW-1:0])
          dir_ff[i] <= link.virtual_address_register[`PRD_SEC_HI:`PRD_SEC_LO];
      end
    end
  end
  assign link.done                    = st_ff.done;
  assign link.io_bus_holding_register = st_ff.hold;
  assign wb_dat_o     = st_ff.wdat;
  assign wb_ack_o     = st_ff.ack;
  assign clr_start_o  = st_ff.clr;
  assign clr_mode_o   = st_ff.clr_mode;
  assign quarter_en_o = st_ff.qen;
  assign dpath_o      = st_ff.dpath;
  assign diag_data_o  = st_ff.ddata;
  assign irq_o        = st_ff.irq;
endmodule : prd_mcu
`default_nettype wire

// ### hw/prd_defines.svh
// Constants for the processor request decoder: field positions, codes and widths.
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH
`define PRD_AW          36
`define PRD_DW          36
`define PRD_SEC_HI      17
`define PRD_SEC_LO      13
`define PRD_PAGE_HI     26
`define PRD_PAGE_LO     18
`define PRD_PHYS_HI     17
`define PRD_PHYS_LO     0
`define PRD_DDIAG_HI    35
`define PRD_DDIAG_LO    30
`define PRD_DSEL_W      3
`define PRD_PT_DEPTH    512
`define PRD_PT_AW       9
`define PRD_DIR_DEPTH   32
`define PRD_DIR_AW      5
`define PRD_RAM_AW      5
`define PRD_RAM_DEPTH   32
`define PRD_DREG_CNT    15
`define PRD_ERRSRC_W    4
`define PRD_SRC_PAR     4'h1
`define PRD_SRC_NXM     4'h2
`define PRD_CCA_QW      3
// Register bus byte offsets.
`define PRD_WB_STAT     4'h0
`define PRD_WB_MASK     4'h4
// Data-path diagnostic source codes.
`define PRD_DP_MB0      6'h00
`define PRD_DP_STORAGE_BUS     6'h01
`define PRD_DP_CACHE    6'h02
`define PRD_DP_CHAN     6'h03
`define PRD_DP_AR       6'h04
// Status bit positions.
`define PRD_IRQ_W       4
`define PRD_IRQ_ERR     0
`define PRD_IRQ_CLR     1
`define PRD_IRQ_RMW     2
`define PRD_IRQ_DIAG    3
`endif

// ### hw/prd_pkg.sv
// Types shared by both ends of the processor request link.
package prd_pkg;
  typedef enum logic [3:0] {
    PRD_OP_NONE   = 4'h0,
    PRD_OP_READ   = 4'h1,
    PRD_OP_WRITE  = 4'h2,
    PRD_OP_RMW1   = 4'h3,
    PRD_OP_RMW2   = 4'h4,
    PRD_OP_WCHK   = 4'h5,
    PRD_OP_SDIAG  = 4'h6,
    PRD_OP_LDREG  = 4'h7,
    PRD_OP_RDREG  = 4'h8,
    PRD_OP_REFILL = 4'h9,
    PRD_OP_MAP    = 4'hA,
    PRD_OP_PTWR   = 4'hB,
    PRD_OP_DIRWR  = 4'hC,
    PRD_OP_DDIAG  = 4'hD
  } prd_op_e;
  typedef enum logic [2:0] {
    PRD_REG_UBR = 3'h0,
    PRD_REG_EBR = 3'h1,
    PRD_REG_CCA = 3'h2,
    PRD_REG_ERA = 3'h3
  } prd_reg_e;
endpackage : prd_pkg

// ### hw/prd_link_if.sv
// Link between the execution unit end and the memory control unit end.
`timescale 1ns/1ps
`default_nettype none
interface prd_link_if;
  logic        execution_request;
  logic        read_qualifier;
  logic        pause_qualifier;
  logic        write_qualifier;
  logic        bus_diagnostic_qualifier;
  logic        load_reg_qualifier;
  logic        read_register_qualifier;
  logic [2:0]  reg_sel;
  logic        map_qualifier;
  logic        refill_wr;
  logic        pt_wr;
  logic        pt_dir_wr;
  logic        newer_paging_mode;
  logic [2:0]  cca_qual;
  logic        diag_read;
  logic        diag_load;
  logic [2:0]  diag_sel;
  logic [35:0] virtual_address_register;
  logic [35:0] arithmetic_register;
  logic [35:0] io_data;
  logic        done;
  logic [35:0] io_bus_holding_register;
  modport exec (
    output execution_request, read_qualifier, pause_qualifier, write_qualifier,
    output bus_diagnostic_qualifier, load_reg_qualifier, read_register_qualifier, reg_sel,
    output map_qualifier, refill_wr, pt_wr, pt_dir_wr, newer_paging_mode, cca_qual,
    output diag_read, diag_load, diag_sel, virtual_address_register, arithmetic_register, io_data,
    input  done, io_bus_holding_register
  );
  modport mcu (
    input  execution_request, read_qualifier, pause_qualifier, write_qualifier,
    input  bus_diagnostic_qualifier, load_reg_qualifier, read_register_qualifier, reg_sel,
    input  map_qualifier, refill_wr, pt_wr, pt_dir_wr, newer_paging_mode, cca_qual,
    input  diag_read, diag_load, diag_sel, virtual_address_register, arithmetic_register, io_data,
    output done, io_bus_holding_register
  );
endinterface : prd_link_if
`default_nettype wire

// ### hw/prd_decode.sv
// Qualifier decoder: turns one request's qualifier pattern into an operation code.
`timescale 1ns/1ps
`default_nettype none
module prd_decode (
  // Qualifiers
  input  wire logic        req_i,
  input  wire logic        rd_i,
  input  wire logic        pause_i,
  input  wire logic        wr_i,
  input  wire logic        sdiag_i,
  input  wire logic        ldreg_i,
  input  wire logic        rdreg_i,
  input  wire logic        map_i,
  input  wire logic        refill_i,
  input  wire logic        ptwr_i,
  input  wire logic        dirwr_i,
  input  wire logic        dload_i,
  // Result
  output var prd_pkg::prd_op_e op_o
);
  import prd_pkg::*;
  // ---------------------------------------------------------------
  // Pattern match
  // ---------------------------------------------------------------
  // Page table writes and diagnostic loads need no request strobe.
  always_comb begin
    op_o = PRD_OP_NONE;
    if (dload_i) begin
      op_o = PRD_OP_DDIAG;
    end else if (dirwr_i) begin
      op_o = PRD_OP_DIRWR;
    end else if (ptwr_i) begin
      op_o = PRD_OP_PTWR;
    end else if (req_i) begin
      if (sdiag_i) begin
        op_o = PRD_OP_SDIAG;
      end else if (refill_i) begin
        op_o = PRD_OP_REFILL;
      end else if (ldreg_i) begin
        op_o = PRD_OP_LDREG;
      end else if (rdreg_i && map_i) begin
        op_o = PRD_OP_MAP;
      end else if (rdreg_i) begin
        op_o = PRD_OP_RDREG;
      end else if (rd_i && pause_i && wr_i) begin
        op_o = PRD_OP_RMW1;
      end else if (pause_i && wr_i) begin
        op_o = PRD_OP_WCHK;
      // write only, second half when armed.
      end else if (wr_i && !rd_i && !pause_i) begin
        op_o = PRD_OP_WRITE;
      end else if (rd_i) begin
        op_o = PRD_OP_READ;
      end
    end
  end
endmodule : prd_decode
`default_nettype wire

// ### hw/prd_exec.sv
// Execution unit end: issues one qualified request per user command and waits for done; strobe-only commands end after one cycle.
`timescale 1ns/1ps
`default_nettype none
module prd_exec (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // User command
  input  wire logic              cmd_valid_i,
  input  wire prd_pkg::prd_op_e  cmd_op_i,
  input  wire logic [2:0]        cmd_reg_i,
  input  wire logic [35:0]       cmd_addr_i,
  input  wire logic [35:0]       cmd_data_i,
  input  wire logic              newer_mode_i,
  output logic                   busy_o,
  output logic                   rsp_valid_o,
  output logic [35:0]            rsp_data_o,
  // Link
  prd_link_if.exec               link
);
  import prd_pkg::*;
  typedef struct packed {
    logic        busy;
    logic        rsp;
    logic [35:0] rdata;
    prd_op_e     op;
    logic [2:0]  rsel;
    logic [35:0] addr;
    logic [35:0] data;
    logic        nm;
  } prd_exec_s;
  prd_exec_s st_ff, nxt_st;
  logic one_shot;
  // ---------------------------------------------------------------
  // Request sequencing
  // ---------------------------------------------------------------
  // Strobe-only operations finish in the cycle they are driven.
  assign one_shot = (st_ff.op == PRD_OP_PTWR) || (st_ff.op == PRD_OP_DIRWR) || (st_ff.op == PRD_OP_DDIAG);
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp = 1'b0;
    if (!st_ff.busy && cmd_valid_i) begin
      nxt_st.busy = 1'b1;
      nxt_st.op   = cmd_op_i;
      nxt_st.rsel = cmd_reg_i;
      nxt_st.addr = cmd_addr_i;
      nxt_st.data = cmd_data_i;
      nxt_st.nm   = newer_mode_i;
    end else if (st_ff.busy && (link.done || one_shot)) begin
      nxt_st.busy  = 1'b0;
      nxt_st.rsp   = 1'b1;
      nxt_st.rdata = link.io_bus_holding_register;
    end
    if (rst_i) begin
      nxt_st = '0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (ce_i || rst_i) begin
      st_ff <= nxt_st;
    end
  end
  // ---------------------------------------------------------------
  // Qualifier drive
  // ---------------------------------------------------------------
  always_comb begin
    link.execution_request        = st_ff.busy && !one_shot;
    // read, pause and write for first half.
    link.read_qualifier           = st_ff.busy && (st_ff.op == PRD_OP_READ || st_ff.op == PRD_OP_RMW1);
    link.pause_qualifier          = st_ff.busy && (st_ff.op == PRD_OP_RMW1 || st_ff.op == PRD_OP_WCHK);
    link.write_qualifier          = st_ff.busy && (st_ff.op == PRD_OP_WRITE || st_ff.op == PRD_OP_RMW1 ||
                                    st_ff.op == PRD_OP_RMW2 || st_ff.op == PRD_OP_WCHK);
    // diagnostic qualifier with control word in arithmetic register.
    link.bus_diagnostic_qualifier = st_ff.busy && st_ff.op == PRD_OP_SDIAG;
    link.load_reg_qualifier       = st_ff.busy && st_ff.op == PRD_OP_LDREG;
    link.read_register_qualifier  = st_ff.busy && (st_ff.op == PRD_OP_RDREG || st_ff.op == PRD_OP_MAP);
    link.map_qualifier            = st_ff.busy && st_ff.op == PRD_OP_MAP;
    link.refill_wr                = st_ff.busy && st_ff.op == PRD_OP_REFILL;
    link.pt_wr                    = st_ff.busy && st_ff.op == PRD_OP_PTWR;
    link.pt_dir_wr                = st_ff.busy && st_ff.op == PRD_OP_DIRWR;
    // diagnostic load value on data bits 30-35.
    link.diag_load                = st_ff.busy && st_ff.op == PRD_OP_DDIAG;
    // Front-end diagnostic read rides along with register reads so both views line up.
    link.diag_read                = st_ff.busy && st_ff.op == PRD_OP_RDREG;
    link.diag_sel                 = st_ff.rsel;
    link.reg_sel                  = st_ff.rsel;
    link.cca_qual                 = st_ff.data[2:0];
    link.newer_paging_mode        = st_ff.nm;
    link.virtual_address_register = st_ff.addr;
    link.arithmetic_register      = st_ff.data;
    link.io_data                  = st_ff.data;
  end
  assign busy_o      = st_ff.busy;
  assign rsp_valid_o = st_ff.rsp;
  assign rsp_data_o  = st_ff.rdata;
endmodule : prd_exec
`default_nettype wire

// ### testbench/prd_link_assertions.sv
// Checker on the link between the execution unit end and the memory control unit end.
`timescale 1ns/1ps
`default_nettype none
module prd_link_assertions (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link signals
  input wire logic        execution_request,
  input wire logic        read_qualifier,
  input wire logic        pause_qualifier,
  input wire logic        write_qualifier,
  input wire logic        bus_diagnostic_qualifier,
  input wire logic        pt_wr,
  input wire logic        pt_dir_wr,
  input wire logic        diag_load,
  input wire logic        done,
  input wire logic [35:0] io_bus_holding_register
);
  // ----------------------------------------
  // Link relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rmw1;
    execution_request && read_qualifier && pause_qualifier |-> write_qualifier;
  endproperty
  a_rmw1: assert property (p_rmw1) else $error("first half without write");
  property p_rmw2;
    execution_request && write_qualifier && !pause_qualifier |-> !read_qualifier;
  endproperty
  a_rmw2: assert property (p_rmw2) else $error("second half carries read");
  property p_sdiag;
    execution_request && bus_diagnostic_qualifier |-> !(read_qualifier || pause_qualifier || write_qualifier);
  endproperty
  a_sdiag: assert property (p_sdiag) else $error("bus diagnostic mixed with memory qualifiers");
  property p_answer;
    $rose(execution_request) |=> done;
  endproperty
  a_answer: assert property (p_answer) else $error("done not one cycle after request");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_cause;
    done |-> $past(execution_request);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  // Holding value may only move as the answer to a request.
  property p_hold;
    $changed(io_bus_holding_register) |-> $past(execution_request);
  endproperty
  a_hold: assert property (p_hold) else $error("holding register changed unasked");
  property p_nostrobe;
    pt_wr || pt_dir_wr || diag_load |-> !execution_request;
  endproperty
  a_nostrobe: assert property (p_nostrobe) else $error("table write with request strobe");
  property p_dload;
    diag_load |=> !diag_load;
  endproperty
  a_dload: assert property (p_dload) else $error("diagnostic load held too long");
endmodule : prd_link_assertions
`default_nettype wire

// ### testbench/processor_request_decode_test.sv
// Self-checking bench for both ends of the processor request link.
`timescale 1ns/1ps
`default_nettype none
module processor_request_decode_test;
  import prd_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cmd_valid = 1'b0;
  prd_op_e     cmd_op = PRD_OP_NONE;
  logic [2:0]  cmd_reg = 3'h0;
  logic [35:0] cmd_addr = 36'h0, cmd_data = 36'h0, rsp_data, dpath, r;
  logic        busy, rsp_valid, par = 1'b0, nonexistent_memory_error = 1'b0, irq, ack;
  logic [35:0] cur = 36'h0, storage_bus = 36'hA_1111_1111, cache = 36'hB_2222_2222, chan = 36'hC_3333_3333;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, w;
  logic [2:0]  mode;
  logic [35:0] dexp [5];
  logic [3:0]  qen;
  logic        clr;
  logic [35:0] dd;
  int          n_clr = 0;
  int          err_count = 0;
  int          n_tests = 0;
  prd_link_if i_prd_link_if ();
  prd_exec i_prd_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
    .cmd_reg_i(cmd_reg), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .newer_mode_i(1'b0), .busy_o(busy),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .link(i_prd_link_if));
  prd_mcu i_prd_mcu (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(i_prd_link_if), .par_err_i(par),
    .nxm_err_i(nonexistent_memory_error), .cur_addr_i(cur), .storage_bus_data_i(storage_bus), .cache_data_i(cache), .chan_data_i(chan),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .clr_start_o(clr), .clr_mode_o(mode), .quarter_en_o(qen), .dpath_o(dpath),
    .diag_data_o(dd), .irq_o(irq));
  prd_link_assertions i_prd_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .execution_request(i_prd_link_if.execution_request), .read_qualifier(i_prd_link_if.read_qualifier),
    .pause_qualifier(i_prd_link_if.pause_qualifier), .write_qualifier(i_prd_link_if.write_qualifier),
    .bus_diagnostic_qualifier(i_prd_link_if.bus_diagnostic_qualifier), .pt_wr(i_prd_link_if.pt_wr),
    .pt_dir_wr(i_prd_link_if.pt_dir_wr), .diag_load(i_prd_link_if.diag_load), .done(i_prd_link_if.done),
    .io_bus_holding_register(i_prd_link_if.io_bus_holding_register));
  // 40 MHz clock.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Counts clear-start pulses; one load must give exactly one.
  always @(posedge clk_i) begin
    if (clr === 1'b1) n_clr++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Outputs are read at the edge, before that edge's updates land, as a flop would.
  task automatic cmd(input prd_op_e op, input logic [2:0] rg, input logic [35:0] a, input logic [35:0] d);
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_reg <= rg;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    // Every command ends in a response pulse; only the watchdog ends a hang.
    do begin
      @(posedge clk_i);
    end while (rsp_valid !== 1'b1);
    r = rsp_data;
  endtask : cmd
  // Classic cycle held until ack is sampled high; a missing ack hangs until the watchdog.
  task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    w = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #50us;
    err_count++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    dexp = '{36'h0, storage_bus, cache, chan, 36'h1_0000_0000};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      cmd(PRD_OP_LDREG, 3'(i), 36'h1230 + 36'(i), 36'h0);
      cmd(PRD_OP_RDREG, 3'(i), 36'h0, 36'h0);
      check("base register", 36'h1230 + 36'(i), r);
      check("diagnostic read", 36'h1230 + 36'(i), dd);
    end
    // Both errors together first: parity must win the source code.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      par <= (i == 0);
      nonexistent_memory_error <= 1'b1;
      cur <= 36'h0_89AB_CDE0 + 36'(i);
      @(posedge clk_i);
      par <= 1'b0;
      nonexistent_memory_error <= 1'b0;
      cmd(PRD_OP_RDREG, 3'h3, 36'h0, 36'h0);
      check("error address", {32'h89AB_CDE0 + 32'(i), 4'(i + 1)}, r);
    end
    cmd(PRD_OP_LDREG, 3'h2, 36'h200, 36'h5);
    check("clear mode", 36'h5, 36'(mode));
    check("clear start", 36'h1, 36'(n_clr));
    cmd(PRD_OP_RMW1, 3'h0, 36'h100, 36'h0);
    cmd(PRD_OP_WRITE, 3'h0, 36'h100, 36'h77);
    cmd(PRD_OP_SDIAG, 3'h0, 36'h0, 36'h1);
    wb(1'b0, 4'h0, 32'h0);
    check("status", 36'hF, 36'(w));
    check("irq masked", 36'h0, 36'(irq));
    wb(1'b1, 4'h4, 32'h4);
    @(posedge clk_i);
    check("irq unmasked", 36'h1, 36'(irq));
    wb(1'b1, 4'h0, 32'hF);
    @(posedge clk_i);
    check("irq cleared", 36'h0, 36'(irq));
    wb(1'b0, 4'h0, 32'h0);
    check("status cleared", 36'h0, 36'(w));
    wb(1'b0, 4'hC, 32'h0);
    check("unmapped", 36'h0, 36'(w));
    cmd(PRD_OP_REFILL, 3'h0, 36'h3, 36'hA);
    check("quarters", 36'hA, 36'(qen));
    cmd(PRD_OP_PTWR, 3'h0, 36'h0_0014_0000, 36'h3_1234);
    cmd(PRD_OP_MAP, 3'h0, 36'h0_0014_0000, 36'h0);
    check("map", 36'h3_1234, {18'h0, r[17:0]});
    for (int i = 0; i < 5; i++) begin
      cmd(PRD_OP_DDIAG, 3'h0, 36'h0, {6'(i), 30'h0});
      repeat (2) @(posedge clk_i);
      check("data path", dexp[i], dpath);
    end
    finish_test();
  end
endmodule : processor_request_decode_test
`default_nettype wire
